/* File: rtl/mmd_access_pkg.sv */
// Shared constants for the indirect extended-register access path
package mmd_access_pkg;
	localparam int REG_AW = 5;
	localparam int REG_DW = 16;
	localparam logic [4:0] DIRECT_LAST = 5'h1F;
	localparam logic [4:0] ACCESS_CONTROL_OFS = 5'h0D;
	localparam logic [4:0] ADDRESS_DATA_OFS = 5'h0E;
	localparam int DEV_SEL_LSB = 0;
	localparam int DEV_SEL_W = 5;
	localparam int FUNC_LSB = 14;
	localparam int FUNC_W = 2;
	localparam logic [4:0] DEV_VENDOR = 5'h1F;
	localparam logic [4:0] DEV_PMA = 5'h01;
	localparam logic [1:0] FUNC_ADDR = 2'h0;
	localparam logic [1:0] FUNC_DATA = 2'h1;
	localparam logic [1:0] FUNC_DATA_INC_RW = 2'h2;
	localparam logic [1:0] FUNC_DATA_INC_WR = 2'h3;
	localparam logic [15:0] ACCESS_CONTROL_RST = 16'h0000;
	localparam logic [15:0] POINTER_RST = 16'h0000;
	// Controller command register offsets
	localparam logic [3:0] CMD_CONTROL_OFS = 4'h0;
	localparam logic [3:0] CMD_WDATA_OFS = 4'h1;
	localparam logic [3:0] CMD_RDATA_OFS = 4'h2;
	localparam logic [3:0] CMD_STATUS_OFS = 4'h3;
endpackage : mmd_access_pkg

/* File: rtl/mmd_mgmt_if.sv */
// Clause 22 style register port between management entity and device
`timescale 1ns/1ps
interface mmd_mgmt_if;
	logic wr_en;
	logic rd_en;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport device (input wr_en, input rd_en, input addr, input wdata,
		output rdata);
	modport station (output wr_en, output rd_en, output addr,
		output wdata, input rdata);
endinterface : mmd_mgmt_if

/* File: rtl/mmd_device_end.sv */
// Device end: direct register file plus indirect extended-space access
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module mmd_device_end
	import mmd_access_pkg::*;
#(
	parameter int EXT_DEPTH = 64
)
(
	input wire logic CLK_IN, // 200 MHz clock
	input wire logic RSTN_IN, // Synchronous reset, active low
	mmd_mgmt_if.device MGMT, // Register port from station
	output logic [15:0] POINTER_VENDOR_OUT, // Vendor-space pointer
	output logic [15:0] POINTER_PMA_OUT // PMA-space pointer
);
	localparam int EW = $clog2(EXT_DEPTH);
	localparam int SPACES = 2;
	// Space 0 is the vendor space, space 1 the medium-attachment space
	localparam int VENDOR_IDX = 0;
	localparam int PMA_IDX = 1;
	logic [15:0] direct_mem [0:31];
	logic [15:0] access_control_ff;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic [4:0] dev_sel;
	logic [1:0] func;
	logic [SPACES-1:0] space_hit;
	logic [SPACES-1:0][15:0] ptr_all;
	logic [SPACES-1:0][15:0] word_all;
	logic sel_vendor;
	logic sel_ok;
	logic [15:0] cur_ptr;
	logic [15:0] cur_word;
	logic [EW-1:0] cur_idx;

	// Strobe and function decode results
	logic ctl_wr;
	logic ad_hit;
	logic ad_wr;
	logic ad_rd;
	logic ptr_load;
	logic data_wr;
	logic data_rd;
	logic direct_wr;
	logic inc_on_wr;
	logic inc_on_rd;
	logic step;

	// Field decode of the access control register
	// Both fields are live at once, so one write retargets everything
	assign dev_sel = access_control_ff[DEV_SEL_LSB +: DEV_SEL_W];
	assign func = access_control_ff[FUNC_LSB +: FUNC_W];
	assign sel_vendor = space_hit[VENDOR_IDX];
	assign sel_ok = |space_hit;

	// Only one space can match, so picking vendor-or-else is safe
	assign cur_ptr = sel_vendor ? ptr_all[VENDOR_IDX] : ptr_all[PMA_IDX];
	assign cur_word = sel_vendor ? word_all[VENDOR_IDX] : word_all[PMA_IDX];
	// Pointer beyond the implemented depth aliases; upper bits ignored
	assign cur_idx = cur_ptr[EW-1:0];

	// Strobe decode for the two indirect registers and the plain ones
	assign ctl_wr = MGMT.wr_en && MGMT.addr == ACCESS_CONTROL_OFS;
	assign ad_hit = (MGMT.addr == ADDRESS_DATA_OFS) && sel_ok;
	assign ad_wr = ad_hit && MGMT.wr_en;
	assign ad_rd = ad_hit && MGMT.rd_en;
	assign ptr_load = ad_wr && (func == FUNC_ADDR);
	assign data_wr = ad_wr && (func != FUNC_ADDR);
	assign data_rd = ad_rd && (func != FUNC_ADDR);
	assign direct_wr = MGMT.wr_en && (MGMT.addr != ACCESS_CONTROL_OFS) &&
		(MGMT.addr != ADDRESS_DATA_OFS);

	// Function decode: which data accesses move the pointer afterwards
	always_comb
	begin
		inc_on_wr = 1'b0;
		inc_on_rd = 1'b0;
		case (func)
			FUNC_DATA_INC_RW:
			begin
				inc_on_wr = 1'b1;
				inc_on_rd = 1'b1;
			end
			FUNC_DATA_INC_WR:
				inc_on_wr = 1'b1;
			default:
			begin
				inc_on_wr = 1'b0;
				inc_on_rd = 1'b0;
			end
		endcase
	end

	// Step only on an access that actually reached a supported space
	assign step = (data_wr && inc_on_wr) || (data_rd && inc_on_rd);

	// Access control register itself
	always_ff @(posedge CLK_IN)
	begin
		if (!RSTN_IN)
			access_control_ff <= ACCESS_CONTROL_RST;
		else if (ctl_wr)
			access_control_ff <= MGMT.wdata;
	end

	// One pointer and one store per space, so switching spaces keeps
	// each position; storage is not reset and reads unknown until written
	for (genvar s = 0; s < SPACES; s++)
	begin : g_space
		localparam logic [4:0] CODE = (s == VENDOR_IDX) ? DEV_VENDOR : DEV_PMA;
		logic [15:0] ptr_ff;
		logic [15:0] nxt_ptr;
		logic [15:0] store [0:EXT_DEPTH-1];

		assign space_hit[s] = (dev_sel == CODE);
		assign ptr_all[s] = ptr_ff;
		assign word_all[s] = store[cur_idx];

		// Next pointer: a load wins over a post-increment
		always_comb
		begin
			nxt_ptr = ptr_ff;
			if (ptr_load)
				nxt_ptr = MGMT.wdata;
			else if (step)
				nxt_ptr = ptr_ff + 16'h0001; // wraps to zero
		end

		// Pointer moves only while its own space is selected
		always_ff @(posedge CLK_IN)
		begin
			if (!RSTN_IN)
				ptr_ff <= POINTER_RST;
			else if (space_hit[s])
				ptr_ff <= nxt_ptr;
		end

		// Extended registers, written through the pointer
		always_ff @(posedge CLK_IN)
		begin
			if (data_wr && space_hit[s])
				store[cur_idx] <= MGMT.wdata;
		end
	end

	// Plain direct registers; 0xD and 0xE are routed elsewhere
	// Not reset, so software must write before it trusts a read
	always_ff @(posedge CLK_IN)
	begin
		if (direct_wr)
			direct_mem[MGMT.addr] <= MGMT.wdata;
	end

	// Read source picked by address; an ignored access reads as zero
	// so a wrong space select never leaks stale extended data
	always_comb
	begin
		nxt_rdata = 16'h0000;
		case (MGMT.addr)
			ACCESS_CONTROL_OFS:
				nxt_rdata = access_control_ff;
			ADDRESS_DATA_OFS:
			begin
				if (!sel_ok)
					nxt_rdata = 16'h0000;
				else if (func == FUNC_ADDR)
					nxt_rdata = cur_ptr;
				else
					nxt_rdata = cur_word;
			end
			default:
				nxt_rdata = direct_mem[MGMT.addr];
		endcase
	end

	// Read data one cycle after the read strobe, held until the next
	always_ff @(posedge CLK_IN)
	begin
		if (!RSTN_IN)
			rdata_ff <= 16'h0000;
		else if (MGMT.rd_en)
			rdata_ff <= nxt_rdata;
	end

	// Pointers exposed for observation
	assign MGMT.rdata = rdata_ff;
	assign POINTER_VENDOR_OUT = ptr_all[VENDOR_IDX];
	assign POINTER_PMA_OUT = ptr_all[PMA_IDX];
endmodule : mmd_device_end

/* File: rtl/mmd_station_end.sv */
// Station end: runs indirect access sequences on command from software
`timescale 1ns/1ps
module mmd_station_end
	import mmd_access_pkg::*;
(
	input wire logic CLK_IN, // 200 MHz clock
	input wire logic RSTN_IN, // Synchronous reset, active low
	input wire logic [3:0] ADDR_IN, // Command register address
	input wire logic [15:0] WDATA_IN, // Command write data
	input wire logic WR_IN, // Command write strobe
	input wire logic RD_IN, // Command read strobe
	output logic [15:0] RDATA_OUT, // Command read data, next cycle
	mmd_mgmt_if.station MGMT // Register port toward device
);
	typedef enum {ST_IDLE, ST_SEL_A, ST_PTR, ST_SEL_D, ST_DATA, ST_RWAIT}
		state_e;
	// Control word: [15:14] func, [4:0] space, [8] read, [9] skip pointer
	logic [15:0] control_ff;
	logic [15:0] wdata_ff;
	logic [15:0] rdata_ff;
	logic [15:0] cmd_rdata_ff;
	logic busy_ff;
	logic done_ff;
	state_e state_ff;
	logic wr_ff;
	logic rd_ff;
	logic rd_dly_ff;
	logic [4:0] addr_ff;
	logic [15:0] out_ff;
	logic start;

	assign start = WR_IN && ADDR_IN == CMD_CONTROL_OFS && !busy_ff;

	// Software-visible command registers
	always_ff @(posedge CLK_IN)
	begin
		if (!RSTN_IN)
		begin
			control_ff <= 16'h0000;
			wdata_ff <= 16'h0000;
		end
		else if (WR_IN && !busy_ff)
		begin
			if (ADDR_IN == CMD_CONTROL_OFS)
				control_ff <= WDATA_IN;
			else if (ADDR_IN == CMD_WDATA_OFS)
				wdata_ff <= WDATA_IN;
		end
	end

	// Sequencer: space select, pointer load, function select, data
	always_ff @(posedge CLK_IN)
	begin
		if (!RSTN_IN)
		begin
			state_ff <= ST_IDLE;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			rd_dly_ff <= 1'b0;
			addr_ff <= 5'h00;
			out_ff <= 16'h0000;
			rdata_ff <= 16'h0000;
		end
		else
		begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			rd_dly_ff <= rd_ff;
			if (start)
				done_ff <= 1'b0;
			case (state_ff)
				ST_IDLE:
					if (start)
					begin
						busy_ff <= 1'b1;
						state_ff <= WDATA_IN[9] ? ST_SEL_D :
							ST_SEL_A;
					end
				ST_SEL_A:
				begin
					wr_ff <= 1'b1; // function 00 first
					addr_ff <= ACCESS_CONTROL_OFS;
					out_ff <= {FUNC_ADDR, 9'h000, control_ff[4:0]};
					state_ff <= ST_PTR;
				end
				ST_PTR:
				begin
					wr_ff <= 1'b1; // pointer before data
					addr_ff <= ADDRESS_DATA_OFS;
					out_ff <= wdata_ff;
					state_ff <= ST_SEL_D;
				end
				ST_SEL_D:
				begin
					wr_ff <= 1'b1;
					addr_ff <= ACCESS_CONTROL_OFS;
					out_ff <= {control_ff[15:14], 9'h000, control_ff[4:0]};
					state_ff <= ST_DATA;
				end
				ST_DATA:
				begin
					addr_ff <= ADDRESS_DATA_OFS;
					out_ff <= wdata_ff;
					if (control_ff[8])
					begin
						rd_ff <= 1'b1;
						state_ff <= ST_RWAIT;
					end
					else
					begin
						wr_ff <= 1'b1;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end
				end
				ST_RWAIT:
					state_ff <= ST_IDLE;
				default:
					state_ff <= ST_IDLE;
			endcase
			// Device registers its answer on the strobe's edge, so the
			// word is only there one edge later
			if (rd_dly_ff)
			begin
				rdata_ff <= MGMT.rdata;
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
			end
		end
	end

	// Command read port, one cycle latency
	always_ff @(posedge CLK_IN)
	begin
		if (!RSTN_IN)
			cmd_rdata_ff <= 16'h0000;
		else if (RD_IN)
		begin
			case (ADDR_IN)
				CMD_CONTROL_OFS: cmd_rdata_ff <= control_ff;
				CMD_WDATA_OFS: cmd_rdata_ff <= wdata_ff;
				CMD_RDATA_OFS: cmd_rdata_ff <= rdata_ff;
				CMD_STATUS_OFS: cmd_rdata_ff <= {14'h0000, done_ff, busy_ff};
				default: cmd_rdata_ff <= 16'h0000;
			endcase
		end
	end

	assign RDATA_OUT = cmd_rdata_ff;
	assign MGMT.wr_en = wr_ff;
	assign MGMT.rd_en = rd_ff;
	assign MGMT.addr = addr_ff;
	assign MGMT.wdata = out_ff;
endmodule : mmd_station_end

/* File: sim/mmd_access_sva.sv */
// Pointer checker for the station to device register port
`timescale 1ns/1ps
module mmd_access_sva
	import mmd_access_pkg::*;
(
	input wire logic CLK_IN, // Clock
	input wire logic RSTN_IN, // Reset, low
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	input wire logic [4:0] addr, // Address
	input wire logic [15:0] wdata, // Write data
	input wire logic [15:0] rdata, // Read data
	input wire logic [15:0] POINTER_VENDOR_OUT, // Vendor pointer
	input wire logic [15:0] POINTER_PMA_OUT // PMA pointer
);
	logic [15:0] ctl_ff;
	wire [15:0] pv = POINTER_VENDOR_OUT;
	wire [15:0] pp = POINTER_PMA_OUT;
	wire [1:0] fn = ctl_ff[15:14];
	wire ven = ctl_ff[4:0] == DEV_VENDOR;
	wire pma = ctl_ff[4:0] == DEV_PMA;
	wire acc = (wr_en | rd_en) && addr == ADDRESS_DATA_OFS;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// Own copy of the control word, so a lost update shows up
	always_ff @(posedge CLK_IN)
	begin
		if (!RSTN_IN)
			ctl_ff <= ACCESS_CONTROL_RST;
		else if (wr_en && addr == ACCESS_CONTROL_OFS)
			ctl_ff <= wdata;
	end
	property p_ld;
		acc && wr_en && fn == FUNC_ADDR && ven |=> pv == $past(wdata);
	endproperty
	a_ld: assert property (p_ld) else $error("load");
	property p_rdp;
		acc && rd_en && fn == FUNC_ADDR && pma |=> rdata == pp;
	endproperty
	a_rdp: assert property (p_rdp) else $error("read ptr");
	property p_inc;
		acc && fn == FUNC_DATA_INC_RW && ven |=> pv == $past(pv) + 16'h1;
	endproperty
	a_inc: assert property (p_inc) else $error("step");
	property p_wro;
		acc && rd_en && fn == FUNC_DATA_INC_WR && ven |=> $stable(pv);
	endproperty
	a_wro: assert property (p_wro) else $error("rd step");
	property p_wri;
		acc && wr_en && fn == FUNC_DATA_INC_WR && ven |=>
			pv == $past(pv) + 16'h1;
	endproperty
	a_wri: assert property (p_wri) else $error("wr step");
	property p_hold;
		acc && fn == FUNC_DATA |=> $stable(pv) && $stable(pp);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_bad;
		acc && !ven && !pma |=> $stable(pv) && $stable(pp);
	endproperty
	a_bad: assert property (p_bad) else $error("bad space");
	property p_sep;
		acc && ven |=> $stable(pp);
	endproperty
	a_sep: assert property (p_sep) else $error("pma moved");
	c_wr: cover property (acc && wr_en && fn == FUNC_DATA_INC_WR);
	c_rd: cover property (acc && rd_en && fn == FUNC_DATA_INC_RW);
	c_bad: cover property (acc && !ven && !pma);
endmodule : mmd_access_sva

/* File: sim/test_indirect_mmd_register_access.sv */
// Bench: station end drives device end through command registers
`timescale 1ns/1ps
module test_indirect_mmd_register_access
	import mmd_access_pkg::*;
;
	logic clk, rstn, wr, rd;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, pv, pp, r;
	int err_count = 0, compares = 0, cyc = 0;
	mmd_mgmt_if mi ();
	mmd_station_end mmd_station_end_inst (.CLK_IN(clk), .RSTN_IN(rstn),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
		.RDATA_OUT(rdata), .MGMT(mi));
	mmd_device_end mmd_device_end_inst (.CLK_IN(clk), .RSTN_IN(rstn),
		.MGMT(mi), .POINTER_VENDOR_OUT(pv), .POINTER_PMA_OUT(pp));
	mmd_access_sva mmd_access_sva_inst (.CLK_IN(clk), .RSTN_IN(rstn),
		.wr_en(mi.wr_en), .rd_en(mi.rd_en), .addr(mi.addr),
		.wdata(mi.wdata), .rdata(mi.rdata), .POINTER_VENDOR_OUT(pv),
		.POINTER_PMA_OUT(pp));
	always #2.5 clk = ~clk;
	// Ceiling far above the few hundred cycles the tests need
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count++;
			results();
		end
	end
	task automatic results();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [15:0] e, g);
		compares++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic ptrs(input logic [15:0] ev, ep);
		chk("vendor pointer", ev, pv);
		chk("pma pointer", ep, pp);
	endtask : ptrs
	task automatic put(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : put
	task automatic get(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask : get
	// One command; busy is polled, the timeout bounds the wait
	task automatic run(input logic [15:0] c, d);
		logic [15:0] s;
		put(CMD_WDATA_OFS, d);
		put(CMD_CONTROL_OFS, c);
		s = 16'h0001;
		while (s[0] !== 1'h0)
			get(CMD_STATUS_OFS, s);
		chk("status", 16'h0002, s);
		get(CMD_RDATA_OFS, r);
	endtask : run
	task automatic t_addr();
		run(16'h001F, 16'h0005);
		ptrs(16'h0005, 16'h0000);
		run(16'h031F, 16'h0000);
		chk("rdata", 16'h0005, r);
		run(16'h421F, 16'hBEEF);
		ptrs(16'h0005, 16'h0000);
		run(16'h411F, 16'h0005);
		chk("rdata", 16'hBEEF, r);
		$display("test addr_data done");
	endtask : t_addr
	task automatic t_inc();
		run(16'hC21F, 16'hA5A5);
		ptrs(16'h0006, 16'h0000);
		run(16'h821F, 16'h5A5A);
		ptrs(16'h0007, 16'h0000);
		run(16'h001F, 16'h0005);
		run(16'hC31F, 16'h0000);
		chk("rdata", 16'hA5A5, r);
		ptrs(16'h0005, 16'h0000);
		run(16'h831F, 16'h0000);
		run(16'h831F, 16'h0000);
		chk("rdata", 16'h5A5A, r);
		ptrs(16'h0007, 16'h0000);
		$display("test increment done");
	endtask : t_inc
	task automatic t_space();
		run(16'h0001, 16'h0030);
		ptrs(16'h0007, 16'h0030);
		run(16'h0301, 16'h0000);
		chk("rdata", 16'h0030, r);
		run(16'h0002, 16'h0077);
		ptrs(16'h0007, 16'h0030);
		run(16'h0302, 16'h0000);
		chk("rdata", 16'h0000, r);
		run(16'h801F, 16'hFFFF);
		ptrs(16'h0000, 16'h0030);
		run(16'h4001, 16'h1234);
		ptrs(16'h0000, 16'h1234);
		run(16'h4101, 16'h1234);
		chk("rdata", 16'h1234, r);
		run(16'hC201, 16'hABCD);
		ptrs(16'h0000, 16'h1235);
		$display("test spaces done");
	endtask : t_space
	// Reset for two cycles, then the scenarios in turn
	initial
	begin
		clk = 1'h0;
		rstn = 1'h0;
		wr = 1'h0;
		rd = 1'h0;
		addr = 4'h0;
		wdata = 16'h0000;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		t_addr();
		t_inc();
		t_space();
		results();
	end
endmodule : test_indirect_mmd_register_access
